// *** logic/ilm_rx_lane_status_monitor.sv ***
// Receive lane synchronisation, alignment and error status monitor
// Overview of operation
// (R1) Per-lane one-bit flag for word-boundary synchronisation errors.
// (R2) Per-lane framing fault when an illegal framing pattern is seen.
// (R3) Per-lane flag for unexpected or illegal control word block type.
// (R4) Per-lane flag for a malformed frame synchronisation word.
// (R5) Per-lane flag when scrambler state differs from descrambler prediction.
// (R6) Per-lane flag when frame length differs from configured length.
// (R7) Per-lane flag for consecutive frame errors.
// (R8) Aligned indication high only while every lane is synced and deskewed.
// (R9) Alignment fault when sync word is not seen on all lanes together.
// (R10) Alignment fault held off until sync word seen once on every lane.
// (R11) Deskew-lost flag on alignment error or loss of alignment.
// (R12) Checksum fault when received control word CRC24 mismatches.
// (R13) Missing start-of-packet detected, corrected and flagged.
// (R14) Missing end-of-packet detected, corrected and flagged.
// (R15) Overflow flag when user side fails to drain arriving data.
// (R16) Burst max code: 0 is 64, 1 is 128, 2 is 192, 3 is 256 bytes.
// (R17) Burst fault on too-short burst or over-long burst.
// (R18) Lane sync status outputs are registered on the system clock.
// (R19) User data moves as 768-bit words in each direction.
// (R20) Word lock after 64 consecutive valid two-bit framing headers.
// (R21) Lane synced only when locked and sync and scrambler words correct.
// (R22) Bit i of each lane vector belongs to lane i, lane 0 at LSB.
`timescale 1ns/1ps

// ********************************************************************
// One receive lane
// ********************************************************************
module ilm_lane (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// Lane word
	input wire logic [ilm_pkg::LANE_W-1:0] word_in,
	input wire logic valid_in,
	input wire logic [15:0] mf_len_in,
	// Status
	output ilm_pkg::ilm_lane_stat_t stat_out
);
	typedef struct packed {
		logic locked;
		logic [6:0] lock_cnt;
		logic [4:0] inv_cnt;
		logic [5:0] win_cnt;
		logic [15:0] pos;
		logic seen;
		logic sync_ok;
		logic scr_ok;
		logic scr_loaded;
		logic [ilm_pkg::SCR_W-1:0] scr;
		logic frame_bad;
		logic [2:0] rep_cnt;
		ilm_pkg::ilm_lane_stat_t stat;
	} ilm_lane_state_t;

	ilm_lane_state_t s_q;
	ilm_lane_state_t s_d;
	logic [1:0] hdr;
	logic fv;
	logic is_ctrl;
	logic [5:0] btype;
	logic known;

	function automatic logic [ilm_pkg::SCR_W-1:0] scr_adv(
		input logic [ilm_pkg::SCR_W-1:0] s);
		scr_adv = {s[ilm_pkg::SCR_W-2:0],
			s[ilm_pkg::SCR_TAP_A] ^ s[ilm_pkg::SCR_TAP_B]};
	endfunction

	assign hdr = word_in[ilm_pkg::HDR_HI:ilm_pkg::HDR_LO];
	assign fv = (hdr == ilm_pkg::HDR_DATA) || (hdr == ilm_pkg::HDR_CTRL);
	assign is_ctrl = (hdr == ilm_pkg::HDR_CTRL);
	assign btype = word_in[ilm_pkg::BT_HI:ilm_pkg::BT_LO];
	// Burst and idle words carry the top bit; the rest must be known types
	assign known = word_in[ilm_pkg::CW_CTRL] ||
		(btype == ilm_pkg::BT_SYNC) || (btype == ilm_pkg::BT_SCRAM) ||
		(btype == ilm_pkg::BT_SKIP) || (btype == ilm_pkg::BT_DIAG);

	always_comb begin
		logic bad_end;
		bad_end = 1'b0;
		s_d = s_q;
		s_d.stat.faults = '0;
		s_d.stat.sync_seen = 1'b0;
		if (valid_in) begin
			if (s_q.scr_loaded) begin
				s_d.scr = scr_adv(s_q.scr);
			end
			if (!s_q.locked) begin
				s_d.lock_cnt = fv ? s_q.lock_cnt + 7'h01 : 7'h00; // [R20]
				if (fv && s_q.lock_cnt == ilm_pkg::LOCK_LAST) begin
					s_d.locked = 1'b1; // [R20]
					s_d.inv_cnt = '0;
					s_d.win_cnt = '0;
					s_d.pos = '0;
				end
			end else begin
				s_d.win_cnt = s_q.win_cnt + 6'h01;
				if (!fv) begin
					s_d.stat.faults.framing_f = 1'b1; // [R2]
					s_d.inv_cnt = s_q.inv_cnt + 5'h01;
					// Too many bad headers in one window: drop lock and rehunt
					if (s_q.inv_cnt == ilm_pkg::LOSS_LAST) begin
						s_d.stat.faults.sync_f = 1'b1; // [R1]
						s_d.locked = 1'b0;
						s_d.lock_cnt = '0;
						s_d.seen = 1'b0;
						s_d.sync_ok = 1'b0;
						s_d.scr_loaded = 1'b0;
					end
				end else if (s_q.win_cnt == ilm_pkg::WIN_LAST) begin
					s_d.inv_cnt = '0;
				end
				if (fv) begin
					s_d.pos = s_q.pos + 16'h0001;
					if (is_ctrl && btype == ilm_pkg::BT_SYNC) begin
						s_d.pos = '0;
						if (word_in[ilm_pkg::DATA_W-1:0] != ilm_pkg::SYNC_WORD) begin
							s_d.stat.faults.sync_word_f = 1'b1; // [R4]
							s_d.sync_ok = 1'b0;
							bad_end = 1'b1;
						end else begin
							s_d.stat.sync_seen = 1'b1;
							s_d.seen = 1'b1;
							s_d.sync_ok = 1'b1;
							if (s_q.seen && s_q.pos != mf_len_in - 16'h0001) begin
								s_d.stat.faults.len_f = 1'b1; // [R6]
								bad_end = 1'b1;
							end
						end
						bad_end = bad_end || s_q.frame_bad;
						s_d.frame_bad = 1'b0;
						s_d.rep_cnt = '0;
						if (bad_end) begin
							s_d.rep_cnt = s_q.rep_cnt + 3'h1;
							if (s_q.rep_cnt == ilm_pkg::REPEAT_LAST) begin
								s_d.stat.faults.repeat_f = 1'b1; // [R7]
								s_d.sync_ok = 1'b0;
								s_d.rep_cnt = '0;
							end
						end
					end else begin
						// Sync word due here but something else came
						if (s_q.seen && s_q.pos == mf_len_in - 16'h0001) begin
							s_d.stat.faults.sync_word_f = 1'b1; // [R4]
							s_d.sync_ok = 1'b0;
							s_d.frame_bad = 1'b1;
						end
						if (is_ctrl && btype == ilm_pkg::BT_SCRAM) begin
							if (s_q.scr_loaded &&
								word_in[ilm_pkg::SCR_W-1:0] != s_q.scr) begin
								s_d.stat.faults.descram_f = 1'b1; // [R5]
								s_d.scr_ok = 1'b0;
								s_d.frame_bad = 1'b1;
							end else begin
								s_d.scr_ok = 1'b1;
							end
							s_d.scr = scr_adv(word_in[ilm_pkg::SCR_W-1:0]);
							s_d.scr_loaded = 1'b1;
						end
						if (is_ctrl && !known) begin
							s_d.stat.faults.block_type_f = 1'b1; // [R3]
						end
					end
				end
			end
		end
		s_d.stat.locked = s_d.locked;
		s_d.stat.synced = s_d.locked && s_d.sync_ok && s_d.scr_ok; // [R21]
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign stat_out = s_q.stat;
endmodule

// ********************************************************************
// Top level
// ********************************************************************
module ilm_rx_lane_status_monitor (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// Avalon-MM register slave
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Receive lanes from the transceiver
	input wire logic [ilm_pkg::NUM_LANES-1:0][ilm_pkg::LANE_W-1:0]
		rx_lane_word_in,
	input wire logic rx_lane_valid_in,
	// Receive user data
	output ilm_pkg::ilm_rx_user_t rx_user_out,
	input wire logic rx_ready_in,
	// Transmit user data towards the transceiver
	input wire logic [ilm_pkg::USER_W-1:0] tx_user_data_in,
	output logic [ilm_pkg::USER_W-1:0] tx_serdes_data_out,
	// Status
	output logic [ilm_pkg::NUM_LANES-1:0] lane_word_locked_out,
	output logic [ilm_pkg::NUM_LANES-1:0] lane_synced_out,
	output ilm_pkg::ilm_lane_faults_t lane_faults_out,
	output logic link_aligned_out,
	output ilm_pkg::ilm_link_faults_t link_faults_out,
	// Transceiver control
	output logic transceiver_reset_request_out,
	output logic transceiver_loopback_select_out
);
	typedef struct packed {
		logic rst_req;
		logic loopback;
		logic [1:0] bmax;
		logic [15:0] mf_len;
		logic [ilm_pkg::NUM_STICKY-1:0][ilm_pkg::NUM_LANES-1:0] sticky;
		logic ack;
		logic [31:0] rdata;
		logic aligned;
		logic [ilm_pkg::NUM_LANES-1:0] armed_lanes;
		logic in_pkt;
		logic [9:0] bytes;
		logic [6:0] fv_cnt;
		ilm_pkg::ilm_link_faults_t link;
		ilm_pkg::ilm_rx_user_t rx;
		logic [ilm_pkg::USER_W-1:0] tx;
	} ilm_top_state_t;

	ilm_top_state_t s_q;
	ilm_top_state_t s_d;
	ilm_pkg::ilm_lane_stat_t [ilm_pkg::NUM_LANES-1:0] lane_stat;
	logic [ilm_pkg::NUM_LANES-1:0] synced_v;
	logic [ilm_pkg::NUM_LANES-1:0] locked_v;
	logic [ilm_pkg::NUM_LANES-1:0] seen_v;
	logic [ilm_pkg::NUM_FAULTS-1:0][ilm_pkg::NUM_LANES-1:0] fault_v;
	logic req;
	logic [9:0] bmax_bytes;
	logic [31:0] wdata;
	logic [3:0] sidx;
	logic in_sticky;

	function automatic logic [ilm_pkg::CRC_W-1:0] crc24(
		input logic [ilm_pkg::DATA_W-1:0] d);
		logic [ilm_pkg::CRC_W-1:0] c;
		logic fb;
		c = ilm_pkg::CRC_INIT;
		for (int k = ilm_pkg::DATA_W - 1; k >= 0; k--) begin
			fb = c[ilm_pkg::CRC_W-1] ^ d[k];
			c = {c[ilm_pkg::CRC_W-2:0], 1'b0} ^ (fb ? ilm_pkg::CRC_POLY : '0);
		end
		crc24 = c;
	endfunction

	// ****************************************************************
	// Lanes
	// ****************************************************************
	for (genvar i = 0; i < ilm_pkg::NUM_LANES; i++) begin : g_lane
		ilm_lane u_lane (
			.sys_clk_in(sys_clk_in),
			.srst_in(srst_in),
			.word_in(rx_lane_word_in[i]),
			.valid_in(rx_lane_valid_in),
			.mf_len_in(s_q.mf_len),
			.stat_out(lane_stat[i])
		);
		assign synced_v[i] = lane_stat[i].synced; // [R22]
		assign locked_v[i] = lane_stat[i].locked;
		assign seen_v[i] = lane_stat[i].sync_seen;
		assign fault_v[0][i] = lane_stat[i].faults.sync_f;
		assign fault_v[1][i] = lane_stat[i].faults.framing_f;
		assign fault_v[2][i] = lane_stat[i].faults.block_type_f;
		assign fault_v[3][i] = lane_stat[i].faults.sync_word_f;
		assign fault_v[4][i] = lane_stat[i].faults.descram_f;
		assign fault_v[5][i] = lane_stat[i].faults.len_f;
		assign fault_v[6][i] = lane_stat[i].faults.repeat_f;
	end

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	assign req = avs_read_in || avs_write_in;
	assign bmax_bytes = ({8'h00, s_q.bmax} + 10'h001) *
		ilm_pkg::BURST_UNIT; // [R16]
	assign wdata = avs_writedata_in & {{8{avs_byteenable_in[3]}},
		{8{avs_byteenable_in[2]}}, {8{avs_byteenable_in[1]}},
		{8{avs_byteenable_in[0]}}};
	assign sidx = avs_address_in[5:2] - ilm_pkg::REG_STICKY0[5:2];
	assign in_sticky = (avs_address_in >= ilm_pkg::REG_STICKY0) &&
		(avs_address_in <= ilm_pkg::REG_STICKY_LAST) &&
		(avs_address_in[1:0] == 2'h0);

	always_comb begin
		logic inp;
		logic [9:0] nb;
		logic [63:0] w;
		logic [1:0] h;
		logic [31:0] rd;
		inp = s_q.in_pkt;
		nb = s_q.bytes;
		w = '0;
		h = '0;
		rd = '0;
		s_d = s_q;
		s_d.link = '0;
		s_d.tx = tx_user_data_in; // [R19]
		s_d.rx.valid = s_q.rx.valid && !rx_ready_in;
		if (rx_lane_valid_in) begin
			s_d.fv_cnt = '0;
			if (rx_lane_word_in[0][ilm_pkg::HDR_HI:ilm_pkg::HDR_LO] ==
				ilm_pkg::HDR_DATA || rx_lane_word_in[0][ilm_pkg::HDR_HI:
				ilm_pkg::HDR_LO] == ilm_pkg::HDR_CTRL) begin
				s_d.fv_cnt = (s_q.fv_cnt == ilm_pkg::CNT_SAT) ? s_q.fv_cnt :
					s_q.fv_cnt + 7'h01;
			end
		end
		// Alignment: lanes are deskewed when their sync words coincide
		s_d.armed_lanes = s_q.armed_lanes | seen_v;
		if (|seen_v && !(&seen_v) && &s_q.armed_lanes) begin
			s_d.link.misaligned_f = 1'b1; // [R9] [R10]
			s_d.link.deskew_lost_f = 1'b1; // [R11]
			s_d.aligned = 1'b0;
		end else if (&seen_v && &synced_v) begin
			s_d.aligned = 1'b1; // [R8]
		end
		if (s_q.aligned && !(&synced_v)) begin
			s_d.aligned = 1'b0; // [R8]
			s_d.link.deskew_lost_f = 1'b1; // [R11]
		end
		// Packet stream walks the lanes in order, lane 0 first
		if (s_q.aligned && rx_lane_valid_in) begin
			if (s_q.rx.valid && !rx_ready_in) begin
				s_d.link.overflow_f = 1'b1; // [R15]
			end
			s_d.rx.valid = 1'b1;
			s_d.rx.sop = '0;
			s_d.rx.eop = '0;
			for (int i = 0; i < ilm_pkg::NUM_LANES; i++) begin
				w = rx_lane_word_in[i][ilm_pkg::DATA_W-1:0];
				h = rx_lane_word_in[i][ilm_pkg::HDR_HI:ilm_pkg::HDR_LO];
				s_d.rx.data[i*ilm_pkg::DATA_W +: ilm_pkg::DATA_W] = w;
				if (h == ilm_pkg::HDR_DATA) begin
					if (!inp) begin
						s_d.link.msop_f = 1'b1; // [R13]
						s_d.rx.sop[i] = 1'b1;
						inp = 1'b1;
					end
					// Saturate just past the limit so the count cannot wrap
					if (nb <= bmax_bytes) begin
						nb = nb + ilm_pkg::BYTES_PER_WORD;
					end
					if (nb > bmax_bytes) begin
						s_d.link.burst_f = 1'b1; // [R17]
					end
				end else if (h == ilm_pkg::HDR_CTRL && w[ilm_pkg::CW_CTRL]) begin
					if (crc24({w[ilm_pkg::DATA_W-1:ilm_pkg::CRC_W],
						{ilm_pkg::CRC_W{1'b0}}}) != w[ilm_pkg::CRC_W-1:0]) begin
						s_d.link.crc_f = 1'b1; // [R12]
					end
					if (nb != '0 && nb < ilm_pkg::BURST_SHORT &&
						!w[ilm_pkg::CW_EOP]) begin
						s_d.link.burst_f = 1'b1; // [R17]
					end
					nb = '0;
					if (w[ilm_pkg::CW_EOP]) begin
						s_d.rx.eop[i] = inp;
						inp = 1'b0;
					end
					if (w[ilm_pkg::CW_SOP]) begin
						if (inp) begin
							s_d.link.meop_f = 1'b1; // [R14]
							s_d.rx.eop[i] = 1'b1;
						end
						s_d.rx.sop[i] = 1'b1;
						inp = 1'b1;
					end
				end
			end
			s_d.in_pkt = inp;
			s_d.bytes = nb;
		end
		// Sticky copies: a new event wins over a clear in the same cycle
		for (int f = 0; f < ilm_pkg::NUM_STICKY; f++) begin
			if (avs_write_in && s_q.ack && in_sticky && sidx == 4'(f)) begin
				s_d.sticky[f] = s_q.sticky[f] & ~wdata[ilm_pkg::NUM_LANES-1:0];
			end
			if (f < ilm_pkg::NUM_FAULTS) begin
				s_d.sticky[f] = s_d.sticky[f] | fault_v[f]; // [R1]
			end else begin
				s_d.sticky[f] = s_d.sticky[f] | {5'h00, s_q.link};
			end
		end
		// Register access: one wait cycle, effect at the accepting edge
		s_d.ack = req && !s_q.ack;
		if (avs_write_in && s_q.ack) begin
			case (avs_address_in)
				ilm_pkg::REG_CTRL: begin
					if (avs_byteenable_in[0]) begin
						s_d.rst_req = wdata[ilm_pkg::CTRL_RST_BIT];
						s_d.loopback = wdata[ilm_pkg::CTRL_LOOP_BIT];
						s_d.bmax = wdata[ilm_pkg::CTRL_BMAX_HI:
							ilm_pkg::CTRL_BMAX_LO]; // [R16]
					end
				end
				ilm_pkg::REG_MF_LEN: begin
					if (avs_byteenable_in[0]) s_d.mf_len[7:0] = wdata[7:0];
					if (avs_byteenable_in[1]) s_d.mf_len[15:8] = wdata[15:8];
				end
				default: begin
				end
			endcase
		end
		case (avs_address_in)
			ilm_pkg::REG_CTRL: begin
				rd[ilm_pkg::CTRL_RST_BIT] = s_q.rst_req;
				rd[ilm_pkg::CTRL_LOOP_BIT] = s_q.loopback;
				rd[ilm_pkg::CTRL_BMAX_HI:ilm_pkg::CTRL_BMAX_LO] = s_q.bmax;
			end
			ilm_pkg::REG_MF_LEN: rd[15:0] = s_q.mf_len;
			ilm_pkg::REG_SYNC: begin
				rd[ilm_pkg::NUM_LANES-1:0] = synced_v;
				rd[ilm_pkg::LOCK_FIELD_LO +: ilm_pkg::NUM_LANES] = locked_v;
			end
			ilm_pkg::REG_LINK: rd[0] = s_q.aligned;
			default: begin
				if (in_sticky) begin
					rd[ilm_pkg::NUM_LANES-1:0] = s_q.sticky[sidx[2:0]];
				end
			end
		endcase
		if (req && !s_q.ack) begin
			s_d.rdata = rd;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			s_q <= '0;
			s_q.mf_len <= ilm_pkg::MF_LEN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign avs_waitrequest_out = req && !s_q.ack;
	assign avs_readdata_out = s_q.rdata;
	assign lane_word_locked_out = locked_v; // [R18]
	assign lane_synced_out = synced_v; // [R18]
	assign lane_faults_out = ilm_pkg::ilm_lane_faults_t'(fault_v);
	assign link_aligned_out = s_q.aligned;
	assign link_faults_out = s_q.link;
	assign rx_user_out = s_q.rx; // [R19]
	assign tx_serdes_data_out = s_q.tx;
	assign transceiver_reset_request_out = s_q.rst_req;
	assign transceiver_loopback_select_out = s_q.loopback;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (srst_in);

	a_bus_wait_once: assert property ((req && avs_waitrequest_out) |=>
		!avs_waitrequest_out) else $error("bus answer late");
	a_aligned_all_synced: assert property (link_aligned_out |-> // [R8]
		$past(&synced_v)) else $error("aligned without all lanes");
	a_misalign_armed: assert property (link_faults_out.misaligned_f |-> // [R10]
		$past(&s_q.armed_lanes)) else $error("misalign before armed");
	a_deskew_lost_fall: assert property ($fell(link_aligned_out) |-> // [R11]
		link_faults_out.deskew_lost_f) else $error("silent loss");
	a_synced_locked: assert property (&(locked_v | ~synced_v)) // [R21]
		else $error("synced lane not locked");
	a_lock_after_64: assert property ($rose(locked_v[0]) |-> // [R20]
		$past(s_q.fv_cnt) >= ilm_pkg::LOCK_LAST) else $error("early lock");
	a_sticky_set: assert property (|fault_v[0] |=> // [R1]
		((s_q.sticky[0] & $past(fault_v[0])) == $past(fault_v[0])))
		else $error("sticky bit lost");
	a_overflow_flag: assert property ((s_q.aligned && rx_lane_valid_in && // [R15]
		s_q.rx.valid && !rx_ready_in) |=> link_faults_out.overflow_f)
		else $error("overflow missed");
	a_crc_when_aligned: assert property (link_faults_out.crc_f |-> // [R12]
		$past(s_q.aligned && rx_lane_valid_in)) else $error("stray crc");
	a_rx_word_source: assert property (($rose(rx_user_out.valid)) |-> // [R19]
		$past(s_q.aligned && rx_lane_valid_in)) else $error("stray word");
endmodule

// *** logic/ilm_pkg.sv ***
// Shared constants and carrier types for the receive lane status monitor
package ilm_pkg;
	// ****************************************************************
	// Geometry
	// ****************************************************************
	localparam int NUM_LANES = 12;
	localparam int LANE_W = 67;
	localparam int DATA_W = 64;
	localparam int USER_W = 768;
	localparam int NUM_FAULTS = 7;
	localparam int NUM_STICKY = 8;
	localparam int HDR_HI = 65;
	localparam int HDR_LO = 64;
	localparam logic [1:0] HDR_DATA = 2'h1;
	localparam logic [1:0] HDR_CTRL = 2'h2;
	// ****************************************************************
	// Lane synchronisation
	// ****************************************************************
	localparam logic [6:0] LOCK_LAST = 7'h3F;
	localparam logic [6:0] CNT_SAT = 7'h7F;
	localparam logic [4:0] LOSS_LAST = 5'h0F;
	localparam logic [5:0] WIN_LAST = 6'h3F;
	localparam logic [2:0] REPEAT_LAST = 3'h3;
	localparam int BT_HI = 63;
	localparam int BT_LO = 58;
	localparam logic [5:0] BT_SYNC = 6'h1E;
	localparam logic [5:0] BT_SCRAM = 6'h0A;
	localparam logic [5:0] BT_SKIP = 6'h07;
	localparam logic [5:0] BT_DIAG = 6'h19;
	localparam logic [63:0] SYNC_WORD = 64'h78F6_78F6_78F6_78F6;
	localparam int SCR_W = 58;
	localparam int SCR_TAP_A = 57;
	localparam int SCR_TAP_B = 38;
	localparam logic [15:0] MF_LEN_RST = 16'h0800;
	// ****************************************************************
	// Packet stream
	// ****************************************************************
	localparam int CW_CTRL = 63;
	localparam int CW_SOP = 61;
	localparam int CW_EOP = 60;
	localparam int CRC_W = 24;
	localparam logic [23:0] CRC_POLY = 24'h328B63;
	localparam logic [23:0] CRC_INIT = 24'hFFFFFF;
	localparam logic [9:0] BYTES_PER_WORD = 10'h008;
	localparam logic [9:0] BURST_UNIT = 10'h040;
	localparam logic [9:0] BURST_SHORT = 10'h020;
	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_MF_LEN = 6'h04;
	localparam logic [5:0] REG_SYNC = 6'h08;
	localparam logic [5:0] REG_LINK = 6'h0C;
	localparam logic [5:0] REG_STICKY0 = 6'h10;
	localparam logic [5:0] REG_STICKY_LAST = 6'h2C;
	localparam int CTRL_RST_BIT = 0;
	localparam int CTRL_LOOP_BIT = 1;
	localparam int CTRL_BMAX_LO = 2;
	localparam int CTRL_BMAX_HI = 3;
	localparam int LOCK_FIELD_LO = 16;
	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic repeat_f;
		logic len_f;
		logic descram_f;
		logic sync_word_f;
		logic block_type_f;
		logic framing_f;
		logic sync_f;
	} ilm_fault_bits_t;
	typedef struct packed {
		logic locked;
		logic synced;
		logic sync_seen;
		ilm_fault_bits_t faults;
	} ilm_lane_stat_t;
	typedef struct packed {
		logic [NUM_LANES-1:0] repeat_f;
		logic [NUM_LANES-1:0] len_f;
		logic [NUM_LANES-1:0] descram_f;
		logic [NUM_LANES-1:0] sync_word_f;
		logic [NUM_LANES-1:0] block_type_f;
		logic [NUM_LANES-1:0] framing_f;
		logic [NUM_LANES-1:0] sync_f;
	} ilm_lane_faults_t;
	typedef struct packed {
		logic burst_f;
		logic overflow_f;
		logic meop_f;
		logic msop_f;
		logic crc_f;
		logic deskew_lost_f;
		logic misaligned_f;
	} ilm_link_faults_t;
	typedef struct packed {
		logic [USER_W-1:0] data;
		logic [NUM_LANES-1:0] sop;
		logic [NUM_LANES-1:0] eop;
		logic valid;
	} ilm_rx_user_t;
endpackage

// *** verif/ilm_far_tx.sv ***
// Far-end transmitter model driving framed words on all receive lanes
`timescale 1ns/1ps
module ilm_far_tx #(
	parameter int FRAME_LEN = 32
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// Lanes given an illegal header
	input wire logic [11:0] bad_mask_in,
	// Sync and scrambler state words, from the next edge on
	input wire logic frame_en_in,
	// Lane words
	output logic [ilm_pkg::NUM_LANES-1:0][ilm_pkg::LANE_W-1:0] word_out,
	output logic valid_out
);
	int seed = 74;
	int pos = 0;
	// Any nonzero start; the receiver learns it from the first state word
	logic [ilm_pkg::SCR_W-1:0] st = 58'h1;
	initial begin
		word_out = '0;
		valid_out = 1'b0;
	end
	always @(posedge sys_clk_in) begin
		valid_out <= !srst_in;
		// Advances once per word, as the receiver's prediction does
		st <= {st[ilm_pkg::SCR_W-2:0],
			st[ilm_pkg::SCR_TAP_A] ^ st[ilm_pkg::SCR_TAP_B]};
		pos <= frame_en_in ? (pos + 1) % FRAME_LEN : 0;
		for (int i = 0; i < ilm_pkg::NUM_LANES; i++) begin
			if (frame_en_in && pos == 0) begin
				word_out[i] <= {1'b0, ilm_pkg::HDR_CTRL,
					ilm_pkg::SYNC_WORD};
			end else if (frame_en_in && pos == 1) begin
				word_out[i] <= {1'b0, ilm_pkg::HDR_CTRL,
					ilm_pkg::BT_SCRAM, st};
			end else begin
				// Header 00 is illegal, so only asked-for lanes see faults
				word_out[i] <= {1'b0,
					bad_mask_in[i] ? 2'h0 : ilm_pkg::HDR_DATA,
					$random(seed), $random(seed)};
			end
		end
	end
endmodule

// *** verif/tb_ilm_rx_lane_status_monitor.sv ***
// Self-checking bench for the receive lane status monitor
`timescale 1ns/1ps
module tb_ilm_rx_lane_status_monitor;
	logic sys_clk_in = 1'b0, srst_in = 1'b1, rd_s = 1'b0, wr_s = 1'b0;
	logic wq, fclr = 1'b0, rst_o, loop_o, alg, fen = 1'b0, rdy = 1'b1;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0, rdat, r;
	logic [11:0] bad = 12'h000, facc = 12'h000, sacc = 12'h000, lk, sy;
	logic [11:0] eacc = 12'h000;
	logic [6:0] lacc = 7'h00;
	logic [767:0] txd = '0, txo;
	logic [11:0][66:0] lw;
	logic lv;
	ilm_pkg::ilm_lane_faults_t lf;
	ilm_pkg::ilm_link_faults_t kf;
	ilm_pkg::ilm_rx_user_t ru;
	int seed = 74, miscompares = 0, total_checks = 0, k;
	always #50 sys_clk_in = !sys_clk_in;
	ilm_far_tx ilm_far_tx_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
		.bad_mask_in(bad), .frame_en_in(fen), .word_out(lw),
		.valid_out(lv));
	ilm_rx_lane_status_monitor ilm_rx_lane_status_monitor_inst (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in), .avs_address_in(adr),
		.avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdat),
		.avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wq), .rx_lane_word_in(lw),
		.rx_lane_valid_in(lv), .rx_user_out(ru), .rx_ready_in(rdy),
		.tx_user_data_in(txd), .tx_serdes_data_out(txo),
		.lane_word_locked_out(lk), .lane_synced_out(sy),
		.lane_faults_out(lf), .link_aligned_out(alg), .link_faults_out(kf),
		.transceiver_reset_request_out(rst_o),
		.transceiver_loopback_select_out(loop_o));
	// Fault pulses last one cycle, so they are gathered here
	always @(posedge sys_clk_in) begin
		facc <= fclr ? 12'h000 : facc | lf.framing_f;
		sacc <= fclr ? 12'h000 : sacc | lf.sync_f;
		lacc <= fclr ? 7'h00 : lacc | kf;
		eacc <= fclr ? 12'h000 : eacc | lf.len_f | lf.descram_f |
			lf.sync_word_f | lf.repeat_f | lf.block_type_f;
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	// Holds the request until waitrequest is seen low at a rising edge
	task automatic avs(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		adr <= a;
		wdat <= d;
		wr_s <= w;
		rd_s <= !w;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (wq !== 1'b0 && n < 50);
		q = rdat;
		if (n >= 50) miscompares++;
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#2000000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		step(4);
		srst_in <= 1'b0;
		avs(0, ilm_pkg::REG_MF_LEN, 0, r);
		chk("mf_len", 32'h0000_0800, r);
		avs(0, 6'h30, 0, r);
		chk("unmapped", 32'h0, r);
		k = {$random(seed)} % 4;
		avs(1, ilm_pkg::REG_CTRL, k << 2 | 3, r);
		avs(0, ilm_pkg::REG_CTRL, 0, r);
		chk("ctrl", k << 2 | 3, r);
		chk("gt_ctl", 32'h3, {rst_o, loop_o});
		avs(1, ilm_pkg::REG_CTRL, 0, r);
		$display("registers done");
		k = {$random(seed)} % 12;
		bad <= 12'h001 << k;
		step(80);
		@(negedge sys_clk_in);
		chk("locked", bad ^ 12'hFFF, lk);
		chk("synced", 32'h0, sy);
		chk("aligned", 32'h0, alg);
		avs(0, ilm_pkg::REG_SYNC, 0, r);
		chk("sync_reg", {bad ^ 12'hFFF, 16'h0}, r);
		bad <= 12'h000;
		step(80);
		k = {$random(seed)} % 12;
		fclr <= 1'b1;
		step(1);
		fclr <= 1'b0;
		bad <= 12'h001 << k;
		step(1);
		bad <= 12'h000;
		step(6);
		@(negedge sys_clk_in);
		chk("all_locked", 32'hFFF, lk);
		chk("framing", 12'h001 << k, facc);
		avs(0, 6'h14, 0, r);
		chk("sticky", 12'h001 << k, r);
		avs(1, 6'h14, 12'h001 << k, r);
		avs(0, 6'h14, 0, r);
		chk("cleared", 32'h0, r);
		$display("framing done");
		bad <= 12'h001 << k;
		step(20);
		bad <= 12'h000;
		step(2);
		@(negedge sys_clk_in);
		chk("sync_err", 12'h001 << k, sacc);
		chk("unlocked", (12'h001 << k) ^ 12'hFFF, lk);
		chk("link_faults", 32'h0, lacc);
		$display("lock loss done");
		avs(1, ilm_pkg::REG_MF_LEN, 32'h0000_0020, r);
		fen <= 1'b1;
		step(200);
		@(negedge sys_clk_in);
		chk("aligned_up", 32'h1, alg);
		chk("all_synced", 32'hFFF, sy);
		chk("rx_valid", 32'h1, ru.valid);
		step(1);
		rdy <= 1'b0;
		step(2);
		rdy <= 1'b1;
		step(2);
		@(negedge sys_clk_in);
		chk("link_faults_up", 32'h68, lacc);
		chk("frame_faults", 32'h0, eacc);
		$display("alignment done");
		for (int t = 0; t < 4; t++) begin
			step(1);
			for (int j = 0; j < 24; j++) txd[32*j+:32] <= $random(seed);
			step(1);
			@(negedge sys_clk_in);
			total_checks++;
			if (txo !== txd) begin
				miscompares++;
				$display("BAD tx_data expected %h seen %h", txd, txo);
			end
		end
		$display("transmit done");
		tally_and_finish;
	end
endmodule
